// file: include/cbm_params.svh
// Opcodes, field positions, lengths and reset values of the compare-branch and mask executor
`ifndef CBM_PARAMS_SVH
`define CBM_PARAMS_SVH

`define CBM_OP_AND_DIR 8'h52
`define CBM_OP_CJ_IMM 8'hB4
`define CBM_OP_CJ_DIR 8'hB5
`define CBM_OP_CJ_IND_MASK 8'hFE
`define CBM_OP_CJ_IND 8'hB6
`define CBM_OP_CJ_REG_MASK 8'hF8
`define CBM_OP_CJ_REG 8'hB8
`define CBM_IND_SEL_BIT 0
`define CBM_REG_SEL_MSB 2
`define CBM_LEN_ONE 16'h0001
`define CBM_LEN_AND 16'h0002
`define CBM_LEN_CJ 16'h0003
`define CBM_PC_RESET 16'h0000
`define CBM_BYTE_ZERO 8'h00
`define CBM_REG_COUNT 8

`endif

// file: include/cbm_pkg.sv
// Types shared by the compare-branch and mask executor
package cbm_pkg;
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_OPC,
    ST_BYTE2,
    ST_BYTE3,
    ST_EXEC,
    ST_AND_WR
  } cbm_state_t;

  typedef enum logic [1:0] {
    FORM_IMM,
    FORM_DIR,
    FORM_IND,
    FORM_REG
  } cbm_form_t;
endpackage : cbm_pkg

// file: verilog/cbm_regfile.sv
// Eight working registers with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "cbm_params.svh"

module cbm_regfile (
  input wire logic i_clk,
  input wire logic i_wr,
  input wire logic [2:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [2:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_q [`CBM_REG_COUNT];

  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule : cbm_regfile

`default_nettype wire

// file: verilog/cbm_exec.sv
// Executor for the memory AND and the compare-and-jump-if-not-equal instruction family
// How it works
// - Opcode 52h plus address: AND into memory
// - Bitwise AND written back, accumulator unchanged
// - 1011011r compares indirect byte with immediate
// - B4h compares accumulator with immediate byte
// - B5h compares accumulator with direct byte
// - Any of eight registers compared with immediate
// - Advance by three, add offset if different
// - Equal operands fall through to next instruction
// - Carry set when first operand is smaller
`timescale 1ns/1ps
`default_nettype none
`include "cbm_params.svh"

module cbm_exec (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic [15:0] o_pmem_addr,
  input wire logic [7:0] i_pmem_data,
  output logic [7:0] o_dmem_addr,
  output logic o_dmem_wr,
  output logic [7:0] o_dmem_wdata,
  input wire logic [7:0] i_dmem_rdata,
  input wire logic i_acc_wr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_reg_wr,
  input wire logic [2:0] i_reg_sel,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic [15:0] o_pc,
  output logic o_done,
  output logic o_taken,
  output logic o_bad_op
);
  cbm_pkg::cbm_state_t state_q;
  cbm_pkg::cbm_form_t form_q;
  logic [7:0] opc_q;
  logic [7:0] byte2_q;
  logic [7:0] offset_q;
  logic [7:0] reg_val_q;
  logic [7:0] reg_rdata;
  logic [2:0] reg_raddr;
  logic [7:0] op_first;
  logic [7:0] op_second;
  logic ops_ne;
  logic ops_lt;
  logic [15:0] seq_pc;
  logic [15:0] next_pc;

  function automatic logic is_cj(input logic [7:0] op);
    is_cj = (op == `CBM_OP_CJ_IMM) || (op == `CBM_OP_CJ_DIR) ||
            ((op & `CBM_OP_CJ_IND_MASK) == `CBM_OP_CJ_IND) ||
            ((op & `CBM_OP_CJ_REG_MASK) == `CBM_OP_CJ_REG);
  endfunction : is_cj

  function automatic cbm_pkg::cbm_form_t form_of(input logic [7:0] op);
    if (op == `CBM_OP_CJ_IMM) begin
      form_of = cbm_pkg::FORM_IMM;
    end else if (op == `CBM_OP_CJ_DIR) begin
      form_of = cbm_pkg::FORM_DIR;
    end else if ((op & `CBM_OP_CJ_IND_MASK) == `CBM_OP_CJ_IND) begin
      form_of = cbm_pkg::FORM_IND;
    end else begin
      form_of = cbm_pkg::FORM_REG;
    end
  endfunction : form_of

  function automatic logic [15:0] sext(input logic [7:0] b);
    sext = {{8{b[7]}}, b};
  endfunction : sext

  // Register index is taken straight from the opcode byte while it is on the bus
  always_comb begin
    if ((i_pmem_data & `CBM_OP_CJ_REG_MASK) == `CBM_OP_CJ_REG) begin
      reg_raddr = i_pmem_data[`CBM_REG_SEL_MSB:0];
    end else begin
      reg_raddr = {2'h0, i_pmem_data[`CBM_IND_SEL_BIT]};
    end
  end

  cbm_regfile u_regs (
    .i_clk(i_clk),
    .i_wr(i_reg_wr),
    .i_waddr(i_reg_sel),
    .i_wdata(i_reg_wdata),
    .i_raddr(reg_raddr),
    .o_rdata(reg_rdata)
  );

  always_comb begin
    unique case (form_q)
      cbm_pkg::FORM_IMM: begin
        op_first = o_acc;
        op_second = byte2_q;
      end
      cbm_pkg::FORM_DIR: begin
        op_first = o_acc;
        op_second = i_dmem_rdata;
      end
      cbm_pkg::FORM_IND: begin
        op_first = i_dmem_rdata;
        op_second = byte2_q;
      end
      cbm_pkg::FORM_REG: begin
        op_first = reg_val_q;
        op_second = byte2_q;
      end
    endcase
  end

  assign ops_ne = op_first != op_second;
  assign ops_lt = op_first < op_second;
  assign seq_pc = o_pc + `CBM_LEN_CJ;
  assign next_pc = ops_ne ? seq_pc + sext(offset_q) : seq_pc;

  // Sequencer and program counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= cbm_pkg::ST_FETCH;
      o_pc <= `CBM_PC_RESET;
      o_pmem_addr <= `CBM_PC_RESET;
      o_done <= 1'b0;
      o_taken <= 1'b0;
      o_bad_op <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_taken <= 1'b0;
      o_bad_op <= 1'b0;
      unique case (state_q)
        cbm_pkg::ST_FETCH: begin
          o_pmem_addr <= o_pc + `CBM_LEN_ONE;
          state_q <= cbm_pkg::ST_OPC;
        end
        cbm_pkg::ST_OPC: begin
          if (i_pmem_data == `CBM_OP_AND_DIR || is_cj(i_pmem_data)) begin
            o_pmem_addr <= o_pc + `CBM_LEN_AND;
            state_q <= cbm_pkg::ST_BYTE2;
          end else begin
            // Other opcodes are skipped as one-byte instructions
            o_pc <= o_pc + `CBM_LEN_ONE;
            o_pmem_addr <= o_pc + `CBM_LEN_ONE;
            o_bad_op <= 1'b1;
            o_done <= 1'b1;
            state_q <= cbm_pkg::ST_FETCH;
          end
        end
        cbm_pkg::ST_BYTE2: begin
          state_q <= (opc_q == `CBM_OP_AND_DIR) ? cbm_pkg::ST_AND_WR : cbm_pkg::ST_BYTE3;
        end
        cbm_pkg::ST_BYTE3: begin
          state_q <= cbm_pkg::ST_EXEC;
        end
        cbm_pkg::ST_EXEC: begin
          o_pc <= next_pc;
          o_pmem_addr <= next_pc;
          o_taken <= ops_ne;
          o_done <= 1'b1;
          state_q <= cbm_pkg::ST_FETCH;
        end
        cbm_pkg::ST_AND_WR: begin
          o_pc <= o_pc + `CBM_LEN_AND;
          o_pmem_addr <= o_pc + `CBM_LEN_AND;
          o_done <= 1'b1;
          state_q <= cbm_pkg::ST_FETCH;
        end
        default: begin
          state_q <= cbm_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // Instruction bytes and operand capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      opc_q <= `CBM_BYTE_ZERO;
      byte2_q <= `CBM_BYTE_ZERO;
      offset_q <= `CBM_BYTE_ZERO;
      reg_val_q <= `CBM_BYTE_ZERO;
      form_q <= cbm_pkg::FORM_IMM;
    end else begin
      if (state_q == cbm_pkg::ST_OPC) begin
        opc_q <= i_pmem_data;
        form_q <= form_of(i_pmem_data);
      end
      if (state_q == cbm_pkg::ST_BYTE2) begin
        byte2_q <= i_pmem_data;
        reg_val_q <= reg_rdata;
      end
      if (state_q == cbm_pkg::ST_BYTE3) begin
        offset_q <= i_pmem_data;
      end
    end
  end

  // Data memory port: read address, then a one-cycle write strobe for the AND
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dmem_addr <= `CBM_BYTE_ZERO;
      o_dmem_wr <= 1'b0;
      o_dmem_wdata <= `CBM_BYTE_ZERO;
    end else begin
      o_dmem_wr <= 1'b0;
      if (state_q == cbm_pkg::ST_BYTE2) begin
        o_dmem_addr <= (form_q == cbm_pkg::FORM_IND && opc_q != `CBM_OP_AND_DIR) ? reg_rdata : i_pmem_data;
      end
      if (state_q == cbm_pkg::ST_AND_WR) begin
        o_dmem_wr <= 1'b1;
        o_dmem_wdata <= i_dmem_rdata & o_acc;
      end
    end
  end

  // Accumulator is only written from outside; the AND leaves it alone
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_acc <= `CBM_BYTE_ZERO;
    end else if (i_acc_wr) begin
      o_acc <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_carry <= 1'b0;
    end else if (state_q == cbm_pkg::ST_EXEC) begin
      o_carry <= ops_lt;
    end
  end

  sequence s_cj_body;
    state_q == cbm_pkg::ST_BYTE2 ##1 state_q == cbm_pkg::ST_BYTE3 ##1 state_q == cbm_pkg::ST_EXEC;
  endsequence

  sequence s_and_body;
    state_q == cbm_pkg::ST_BYTE2 ##1 state_q == cbm_pkg::ST_AND_WR ##1 o_dmem_wr;
  endsequence

  property p_and_seq;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == cbm_pkg::ST_OPC && i_pmem_data == `CBM_OP_AND_DIR) |=> s_and_body;
  endproperty
  a_and_seq: assert property (p_and_seq) else $error("AND did not walk to its write");

  property p_and_len;
    @(posedge i_clk) disable iff (!i_rst_n)
      state_q == cbm_pkg::ST_AND_WR |=> o_pc == $past(o_pc) + `CBM_LEN_AND && o_done;
  endproperty
  a_and_len: assert property (p_and_len) else $error("AND did not advance by two");

  property p_and_data;
    @(posedge i_clk) disable iff (!i_rst_n)
      state_q == cbm_pkg::ST_AND_WR |=> o_dmem_wdata == ($past(i_dmem_rdata) & $past(o_acc));
  endproperty
  a_and_data: assert property (p_and_data) else $error("AND result wrong");

  property p_acc_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == cbm_pkg::ST_AND_WR && !i_acc_wr) |=> $stable(o_acc);
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("AND changed accumulator");

  property p_cj_seq;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == cbm_pkg::ST_OPC && is_cj(i_pmem_data)) |=> s_cj_body ##1 o_done;
  endproperty
  a_cj_seq: assert property (p_cj_seq) else $error("Compare did not take its steps");

  property p_eq_fall;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == cbm_pkg::ST_EXEC && !ops_ne) |=> o_pc == $past(o_pc) + `CBM_LEN_CJ && !o_taken;
  endproperty
  a_eq_fall: assert property (p_eq_fall) else $error("Equal compare branched");

  property p_ne_branch;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == cbm_pkg::ST_EXEC && ops_ne) |=>
        o_pc == $past(o_pc) + `CBM_LEN_CJ + sext($past(offset_q)) && o_taken;
  endproperty
  a_ne_branch: assert property (p_ne_branch) else $error("Branch target wrong");

  property p_carry;
    @(posedge i_clk) disable iff (!i_rst_n)
      state_q == cbm_pkg::ST_EXEC |=> o_carry == ($past(op_first) < $past(op_second));
  endproperty
  a_carry: assert property (p_carry) else $error("Carry wrong after compare");
endmodule : cbm_exec

`default_nettype wire

// file: verif/cbm_mem_model.sv
// Program and data memory model facing the executor
`timescale 1ns/1ps
`default_nettype none

module cbm_mem_model (
  input wire logic i_clk,
  input wire logic [15:0] i_pmem_addr,
  output logic [7:0] o_pmem_data,
  input wire logic [7:0] i_dmem_addr,
  input wire logic i_dmem_wr,
  input wire logic [7:0] i_dmem_wdata,
  output logic [7:0] o_dmem_rdata
);
  logic [7:0] pmem [logic [15:0]];
  logic [7:0] dmem [256];

  initial begin
    foreach (dmem[i]) dmem[i] = 8'h00;
  end

  // Data memory reads through in the cycle its address is shown, as the masking write step needs
  assign o_dmem_rdata = dmem[i_dmem_addr];

  // Program memory answers one cycle after its address; unwritten program space reads as zero
  always @(posedge i_clk) begin
    o_pmem_data <= pmem.exists(i_pmem_addr) ? pmem[i_pmem_addr] : 8'h00;
    if (i_dmem_wr === 1'b1) begin
      dmem[i_dmem_addr] <= i_dmem_wdata;
    end
  end
endmodule : cbm_mem_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the compare-branch and mask executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (x)); end end

module testbench;
  typedef struct packed {
    logic [15:0] pc;
    logic [2:0] flags;
    logic [7:0] wdata;
    logic [7:0] acc;
  } cbm_exp_t;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic acc_wr = 1'b0;
  logic reg_wr = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic [7:0] acc_wdata = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] pmem_addr, pc;
  logic [7:0] pmem_data, dmem_addr, dmem_wdata, dmem_rdata, acc;
  logic dmem_wr, carry, done, taken, bad_op;
  logic [7:0] regs [8];
  cbm_exp_t exp_q [$];
  cbm_exp_t m;
  int n_errors = 0;
  int checks = 0;
  int n_done = 0;

  always #12.5 i_clk = ~i_clk;

  cbm_exec uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_pmem_addr(pmem_addr), .i_pmem_data(pmem_data),
    .o_dmem_addr(dmem_addr), .o_dmem_wr(dmem_wr), .o_dmem_wdata(dmem_wdata), .i_dmem_rdata(dmem_rdata),
    .i_acc_wr(acc_wr), .i_acc_wdata(acc_wdata), .i_reg_wr(reg_wr), .i_reg_sel(reg_sel),
    .i_reg_wdata(reg_wdata), .o_acc(acc), .o_carry(carry), .o_pc(pc), .o_done(done), .o_taken(taken),
    .o_bad_op(bad_op));
  cbm_mem_model mdl (.i_clk(i_clk), .i_pmem_addr(pmem_addr), .o_pmem_data(pmem_data),
    .i_dmem_addr(dmem_addr), .i_dmem_wr(dmem_wr), .i_dmem_wdata(dmem_wdata), .o_dmem_rdata(dmem_rdata));

  // Each retirement outside reset takes the oldest expectation; an unexpected one meets all ones
  // A stray retirement of the byte after a scenario lands in the next reset and is not counted
  always @(posedge i_clk) begin
    if (done === 1'b1 && i_rst_n === 1'b1) begin
      n_done++;
      m = '1;
      if (exp_q.size() > 0) begin
        m = exp_q.pop_front();
      end
      `CHK({pc, pmem_addr}, {m.pc, m.pc})
      `CHK({carry, taken, bad_op}, m.flags)
      `CHK(dmem_wr ? dmem_wdata : 8'h00, m.wdata)
      `CHK(acc, m.acc)
    end
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Resets, loads a three-byte program at zero and one data byte, then releases with an accumulator load
  task automatic start(input logic [7:0] op, b2, b3, av, dad, dval);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    mdl.pmem.delete();
    mdl.pmem[16'h0000] = op;
    mdl.pmem[16'h0001] = b2;
    mdl.pmem[16'h0002] = b3;
    mdl.dmem[dad] = dval;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    acc_wr <= 1'b1;
    acc_wdata <= av;
    @(posedge i_clk);
    acc_wr <= 1'b0;
  endtask : start

  task automatic wait_n(input int n);
    int i;
    int d0;
    d0 = n_done;
    for (i = 0; i < 40 && n_done < d0 + n; i++) begin
      @(negedge i_clk);
    end
    if (n_done < d0 + n) begin
      n_errors++;
      conclude();
    end
  endtask : wait_n

  initial begin
    logic [7:0] a, b, ad, off, av;
    int f, k;
    void'($urandom(35689));
    repeat (11) @(posedge i_clk);
    for (k = 0; k < 8; k++) begin
      @(posedge i_clk);
      regs[k] = 8'($urandom);
      reg_wr <= 1'b1;
      reg_sel <= 3'(k);
      reg_wdata <= regs[k];
    end
    @(posedge i_clk);
    reg_wr <= 1'b0;
    // Accumulator masked into a random data byte
    for (k = 0; k < 3; k++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      ad = 8'($urandom);
      start(8'h52, ad, 8'h00, a, ad, b);
      exp_q.push_back('{16'h0002, 3'b000, a & b, a});
      wait_n(1);
      `CHK(mdl.dmem[ad], a & b)
    end
    // Opcodes B4 to BF: immediate, direct, indirect r0/r1, registers 0 to 7
    for (f = 0; f < 12; f++) begin
      for (k = 0; k < 3; k++) begin
        a = (f >= 4) ? regs[f - 4] : 8'($urandom);
        b = (k == 0) ? a : 8'($urandom);
        off = (k == 1) ? 8'h80 : 8'($urandom);
        ad = (f == 2 || f == 3) ? regs[f - 2] : 8'($urandom);
        av = (f < 2) ? a : 8'($urandom);
        start(8'hB4 + 8'(f), (f == 1) ? ad : b, off, av, ad, (f == 1) ? b : a);
        exp_q.push_back('{(a != b) ? 16'h0003 + {{8{off[7]}}, off} : 16'h0003, {a < b, a != b, 1'b0}, 8'h00, av});
        wait_n(1);
      end
    end
    // Carry set by one compare, then cleared by an equal one that follows
    a = 8'($urandom) & 8'h7F;
    start(8'hB4, a + 8'h01, 8'h00, a, 8'h00, 8'h00);
    mdl.pmem[16'h0003] = 8'hB4;
    mdl.pmem[16'h0004] = a;
    mdl.pmem[16'h0005] = 8'hFC;
    exp_q.push_back('{16'h0003, 3'b110, 8'h00, a});
    exp_q.push_back('{16'h0006, 3'b000, 8'h00, a});
    wait_n(2);
    // Unsupported opcode is skipped as one byte
    start(8'h00, 8'h00, 8'h00, a, 8'h00, 8'h00);
    exp_q.push_back('{16'h0001, 3'b001, 8'h00, a});
    wait_n(1);
    conclude();
  end
endmodule : testbench
`default_nettype wire
